/* hw/adc_port_consts.svh */
// Constants shared by both ends of the converter read port.
// Assumes a 40 MHz system clock on both ends.
`ifndef ADC_PORT_CONSTS_SVH
`define ADC_PORT_CONSTS_SVH

`define RES_W           14
`define NUM_CH          4
`define CNT_W           3
`define FIFO_DEPTH      32
`define ADDR_W          16
`define CONV_ADDR       16'h0040
`define CLK_PERIOD_NS   25
`define CONV_CLK_NS     200
`define CONV_DIV        ((`CONV_CLK_NS) / (`CLK_PERIOD_NS))
`define CONV_TICKS      13
`define START_LOW_NS    50
`define START_LOW_CYC   (((`START_LOW_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define SEQ_WAIT_NS     12000
`define SEQ_WAIT_CYC    (((`SEQ_WAIT_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define STROBE_CYC      2

`endif

/* hw/adc_port_pkg.sv */
// Types shared by both ends of the converter read port.
// Assumes adc_port_consts.svh is on the include path.
package adc_port_pkg;

  typedef enum logic [4:0] {
    H_IDLE    = 5'h01,
    H_START   = 5'h02,
    H_WAIT    = 5'h04,
    H_ACCESS  = 5'h08,
    H_RECOVER = 5'h10
  } host_state_e;

  typedef enum logic [1:0] {
    D_IDLE = 2'h1,
    D_CONV = 2'h2
  } dev_state_e;

  typedef enum logic [1:0] {
    WAIT_BUSY  = 2'h0,
    WAIT_DELAY = 2'h1,
    WAIT_EOC   = 2'h2
  } wait_mode_e;

endpackage : adc_port_pkg

/* hw/adc_bus_if.sv */
// Parallel read port between a host and the converter.
// Assumes both ends share clk; resolves the tri-state data bus with a pull-up.
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_consts.svh"

interface adc_bus_if;
  logic               conversion_start_n;
  logic               conv_tick;
  logic               chip_select_n;
  logic               read_n;
  logic               write_n;
  logic [`RES_W-1:0]  result_bus;
  logic               result_oe_n;
  logic               eoc_n;
  logic               busy;
  logic [`RES_W-1:0]  data_seen;

  assign data_seen = result_oe_n ? {`RES_W{1'b1}} : result_bus;

  modport host_mp (
    output conversion_start_n,
    output conv_tick,
    output chip_select_n,
    output read_n,
    output write_n,
    input  data_seen,
    input  eoc_n,
    input  busy
  );

  modport dev_mp (
    input  conversion_start_n,
    input  conv_tick,
    input  chip_select_n,
    input  read_n,
    input  write_n,
    output result_bus,
    output result_oe_n,
    output eoc_n,
    output busy
  );
endinterface : adc_bus_if

`default_nettype wire

/* hw/result_fifo.sv */
// Result FIFO with a registered head word, valid/ready on both sides.
// Assumes one clock, synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module result_fifo #(
  parameter int W     = 14,
  parameter int DEPTH = 32
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [W-1:0]  in_data,
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic [W-1:0]       out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [AW:0]   cnt_ff, nxt_cnt;
  logic          valid_ff, nxt_valid;
  logic [W-1:0]  head_ff, nxt_head;
  logic          push, pop;

  // Full comes straight from the count; output valid comes from the registered head flag
  assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = valid_ff;
  assign out_data  = head_ff;

  always_comb
  begin
    push      = in_valid && in_ready;
    pop       = (cnt_ff != '0) && (!valid_ff || out_ready);
    nxt_wr    = push ? wr_ff + 1'b1 : wr_ff;
    nxt_rd    = pop ? rd_ff + 1'b1 : rd_ff;
    nxt_cnt   = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    nxt_head  = pop ? mem_ff[rd_ff] : head_ff;
    nxt_valid = pop ? 1'b1 : (out_ready ? 1'b0 : valid_ff);
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem_ff[wr_ff] <= in_data;
    if (rst)
    begin
      wr_ff    <= '0;
      rd_ff    <= '0;
      cnt_ff   <= '0;
      valid_ff <= 1'b0;
      head_ff  <= '0;
    end
    else
    begin
      wr_ff    <= nxt_wr;
      rd_ff    <= nxt_rd;
      cnt_ff   <= nxt_cnt;
      valid_ff <= nxt_valid;
      head_ff  <= nxt_head;
    end
  end
endmodule : result_fifo

`default_nettype wire

/* hw/converter_end.sv */
// Converter end: sequences selected channels and serves results on reads.
// Assumes conv_tick and host strobes come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_consts.svh"

module converter_end #(
  parameter int RES_W      = `RES_W,
  parameter int NUM_CH     = `NUM_CH,
  parameter int CONV_TICKS = `CONV_TICKS
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  adc_bus_if.dev_mp                     bus,
  input  wire logic [NUM_CH-1:0]        chan_sel,
  input  wire logic [NUM_CH*RES_W-1:0]  sample_in
);
  localparam int CH_W = $clog2(NUM_CH);
  localparam int TK_W = $clog2(CONV_TICKS + 1);

  adc_port_pkg::dev_state_e state_ff, nxt_state;
  logic [RES_W-1:0] samp_ff [NUM_CH];
  logic [RES_W-1:0] nxt_samp [NUM_CH];
  logic [RES_W-1:0] res_ff [NUM_CH];
  logic [RES_W-1:0] nxt_res [NUM_CH];
  logic [NUM_CH-1:0] sel_ff, nxt_sel;
  logic [CH_W-1:0]   ch_ff, nxt_ch, ptr_ff, nxt_ptr, next_ch;
  logic [TK_W-1:0]   tick_ff, nxt_tick;
  logic [CH_W:0]     done_ff, nxt_done, total_ff, nxt_total, pop;
  logic              busy_ff, nxt_busy, eoc_n_ff, nxt_eoc_n, pend_ff, nxt_pend;
  logic              start_prev_ff, rd_prev_ff, cs_prev_ff, found, wrote, rd_rise;
  logic [RES_W-1:0]  dout_ff, nxt_dout;
  logic              oe_n_ff, nxt_oe_n;

  assign bus.busy        = busy_ff;
  assign bus.eoc_n       = eoc_n_ff;
  assign bus.result_bus  = dout_ff;
  assign bus.result_oe_n = oe_n_ff;

  function automatic logic [CH_W-1:0] advance(input logic [CH_W-1:0] p,
                                              input logic [CH_W:0] total);
    advance = ({1'b0, p} == total - 1'b1) ? '0 : p + 1'b1;
  endfunction : advance

  always_comb
  begin
    nxt_state = state_ff;
    nxt_samp  = samp_ff;
    nxt_res   = res_ff;
    nxt_sel   = sel_ff;
    nxt_ch    = ch_ff;
    nxt_tick  = tick_ff;
    nxt_done  = done_ff;
    nxt_total = total_ff;
    nxt_busy  = busy_ff;
    nxt_ptr   = ptr_ff;
    nxt_pend  = pend_ff;
    nxt_eoc_n = bus.conv_tick ? 1'b1 : eoc_n_ff;
    wrote     = 1'b0;
    found     = 1'b0;
    next_ch   = '0;
    pop       = '0;
    for (int i = NUM_CH - 1; i >= 0; i--)
    begin
      pop = pop + (CH_W+1)'(chan_sel[i]);
      if (sel_ff[i] && (i > int'(ch_ff)))
      begin
        found   = 1'b1;
        next_ch = CH_W'(i);
      end
    end
    case (state_ff)
      adc_port_pkg::D_IDLE:
        if (start_prev_ff && !bus.conversion_start_n && (chan_sel != '0))
        begin
          // All inputs are held at the same instant
          for (int i = 0; i < NUM_CH; i++)
            nxt_samp[i] = sample_in[i*RES_W +: RES_W];
          for (int i = NUM_CH - 1; i >= 0; i--)
            if (chan_sel[i])
              nxt_ch = CH_W'(i);
          nxt_sel   = chan_sel;
          nxt_total = pop;
          nxt_tick  = '0;
          nxt_done  = '0;
          nxt_ptr   = '0;
          nxt_pend  = 1'b0;
          nxt_busy  = 1'b1;
          nxt_state = adc_port_pkg::D_CONV;
        end
      adc_port_pkg::D_CONV:
        if (bus.conv_tick)
        begin
          if (tick_ff == TK_W'(CONV_TICKS - 1))
          begin
            nxt_res[done_ff[CH_W-1:0]] = samp_ff[ch_ff];
            nxt_done  = done_ff + 1'b1;
            nxt_eoc_n = 1'b0;
            wrote     = 1'b1;
            nxt_tick  = '0;
            nxt_ch    = next_ch;
            if (!found)
            begin
              nxt_busy  = 1'b0;
              nxt_state = adc_port_pkg::D_IDLE;
            end
          end
          else
            nxt_tick = tick_ff + 1'b1;
        end
      default:
        nxt_state = adc_port_pkg::D_IDLE;
    endcase
    // Pointer moves on the rising edge of a selected read strobe
    rd_rise = !rd_prev_ff && bus.read_n && !cs_prev_ff;
    if (rd_rise)
    begin
      if (busy_ff && ({1'b0, ptr_ff} + 1'b1 >= done_ff))
        nxt_pend = 1'b1;
      else
        nxt_ptr = advance(ptr_ff, total_ff);
    end
    if (pend_ff && wrote)
    begin
      nxt_ptr  = advance(ptr_ff, total_ff);
      nxt_pend = 1'b0;
    end
    // Registered mux keeps the access inside a zero-wait host cycle
    nxt_dout = res_ff[ptr_ff];
    nxt_oe_n = bus.chip_select_n | bus.read_n;
  end

  always_ff @(posedge clk)
  begin
    samp_ff <= nxt_samp;
    res_ff  <= nxt_res;
    dout_ff <= nxt_dout;
    if (rst)
    begin
      state_ff      <= adc_port_pkg::D_IDLE;
      sel_ff        <= '0;
      ch_ff         <= '0;
      tick_ff       <= '0;
      done_ff       <= '0;
      total_ff      <= '0;
      busy_ff       <= 1'b0;
      eoc_n_ff      <= 1'b1;
      ptr_ff        <= '0;
      pend_ff       <= 1'b0;
      oe_n_ff       <= 1'b1;
      start_prev_ff <= 1'b1;
      rd_prev_ff    <= 1'b1;
      cs_prev_ff    <= 1'b1;
    end
    else
    begin
      state_ff      <= nxt_state;
      sel_ff        <= nxt_sel;
      ch_ff         <= nxt_ch;
      tick_ff       <= nxt_tick;
      done_ff       <= nxt_done;
      total_ff      <= nxt_total;
      busy_ff       <= nxt_busy;
      eoc_n_ff      <= nxt_eoc_n;
      ptr_ff        <= nxt_ptr;
      pend_ff       <= nxt_pend;
      oe_n_ff       <= nxt_oe_n;
      start_prev_ff <= bus.conversion_start_n;
      rd_prev_ff    <= bus.read_n;
      cs_prev_ff    <= bus.chip_select_n;
    end
  end
endmodule : converter_end

`default_nettype wire

/* hw/host_end.sv */
// Host end: starts sequences, decodes the converter location, reads results.
// Assumes the converter end shares clk; ext_start_n is an asynchronous pin.
//
// Overview of operation
// - Busy stays high until all selected channels converted
// - Back-to-back reads return successive stored results
// - Low end-of-conversion pulse after each channel
// - Chip select from memory strobe plus address
// - Data driven only while selected and reading
// - Data valid without host wait states
// - Strobe bus: address strobe and direction form read
// - Chip select also drives transfer acknowledge
// - Start from host or external source
// - Without busy, wait fixed delay before reading
// - Common conversion clock gives identical timing
// - Read enabled while end-of-conversion is low
// - Pointer advances on read edge, wraps at last
// - Mid-sequence read waits for next result
// - Fourteen data lines plus control strobes
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_consts.svh"

module host_end #(
  parameter int RES_W        = `RES_W,
  parameter int FIFO_DEPTH   = `FIFO_DEPTH,
  parameter int SEQ_WAIT_CYC = `SEQ_WAIT_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  adc_bus_if.host_mp                bus,
  input  wire logic                 start_req,
  input  wire logic                 ext_start_n,
  input  wire logic                 use_ext_start,
  input  wire logic                 strobe_bus,
  input  wire logic [1:0]           wait_mode,
  input  wire logic [`CNT_W-1:0]    chan_count,
  output logic                      result_valid,
  input  wire logic                 result_ready,
  output logic [RES_W-1:0]          result_data,
  output logic                      host_idle
);
  localparam int DIV_W = $clog2(`CONV_DIV);

  adc_port_pkg::host_state_e state_ff, nxt_state;
  logic [15:0]         cnt_ff, nxt_cnt;
  logic [`CNT_W-1:0]   left_ff, nxt_left;
  logic [DIV_W-1:0]    div_ff, nxt_div;
  logic                tick_ff, nxt_tick;
  logic                start_n_ff, nxt_start_n;
  logic                dms_n_ff, nxt_dms_n;
  logic [`ADDR_W-1:0]  addr_ff, nxt_addr;
  logic                as_n_ff, nxt_as_n, rw_ff, nxt_rw;
  logic                cs_n_ff, nxt_cs_n, rd_n_ff, nxt_rd_n, ack_n_ff, nxt_ack_n;
  logic                go_ff, nxt_go, push_ff, nxt_push, idle_ff, nxt_idle;
  logic [RES_W-1:0]    pdata_ff, nxt_pdata;
  logic                busy_prev_ff, eoc_prev_ff;
  logic                s1_ff, s2_ff, s3_ff, ext_ff, nxt_ext;
  logic                fifo_ready, go_now;

  assign bus.conversion_start_n = start_n_ff;
  assign bus.conv_tick          = tick_ff;
  assign bus.chip_select_n      = cs_n_ff;
  assign bus.read_n             = rd_n_ff;
  assign bus.write_n            = 1'b1;
  assign host_idle              = idle_ff;

  result_fifo #(
    .W     (RES_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (push_ff),
    .in_ready  (fifo_ready),
    .in_data   (pdata_ff),
    .out_valid (result_valid),
    .out_ready (result_ready),
    .out_data  (result_data)
  );

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_left  = left_ff;
    nxt_go    = go_ff;
    nxt_push  = 1'b0;
    nxt_pdata = pdata_ff;
    nxt_dms_n = dms_n_ff;
    nxt_addr  = addr_ff;
    nxt_as_n  = as_n_ff;
    nxt_rw    = rw_ff;
    // One conversion-clock enable shared by every converter
    nxt_tick  = (div_ff == DIV_W'(`CONV_DIV - 1));
    nxt_div   = nxt_tick ? '0 : div_ff + 1'b1;
    // Change counts only once the second and third stages agree
    nxt_ext   = (s2_ff == s3_ff) ? s3_ff : ext_ff;
    go_now    = 1'b0;
    case (wait_mode)
      adc_port_pkg::WAIT_BUSY:  go_now = busy_prev_ff && !bus.busy;
      adc_port_pkg::WAIT_DELAY: go_now = (cnt_ff >= 16'(SEQ_WAIT_CYC - 1));
      adc_port_pkg::WAIT_EOC:   go_now = eoc_prev_ff && !bus.eoc_n;
      default:                  go_now = 1'b0;
    endcase
    case (state_ff)
      adc_port_pkg::H_IDLE:
      begin
        nxt_go  = 1'b0;
        nxt_cnt = '0;
        if (chan_count != '0)
        begin
          nxt_left = chan_count;
          if (!use_ext_start && start_req)
            nxt_state = adc_port_pkg::H_START;
          else if (use_ext_start && bus.busy && !busy_prev_ff)
            nxt_state = adc_port_pkg::H_WAIT;
        end
      end
      adc_port_pkg::H_START:
      begin
        nxt_cnt = cnt_ff + 1'b1;
        if (cnt_ff == 16'(`START_LOW_CYC - 1))
        begin
          nxt_cnt   = '0;
          nxt_state = adc_port_pkg::H_WAIT;
        end
      end
      adc_port_pkg::H_WAIT:
      begin
        if (cnt_ff != 16'hffff)
          nxt_cnt = cnt_ff + 1'b1;
        nxt_go = go_ff | go_now;
        // A full FIFO stalls the next read until the user drains it
        if ((go_ff || go_now) && fifo_ready)
        begin
          nxt_dms_n = 1'b0;
          nxt_addr  = `CONV_ADDR;
          nxt_as_n  = 1'b0;
          nxt_rw    = 1'b1;
          nxt_cnt   = '0;
          nxt_state = adc_port_pkg::H_ACCESS;
        end
      end
      adc_port_pkg::H_ACCESS:
      begin
        nxt_cnt = cnt_ff + 1'b1;
        if ((cnt_ff >= 16'(`STROBE_CYC - 1)) && (!strobe_bus || !ack_n_ff))
        begin
          nxt_pdata = bus.data_seen;
          nxt_push  = 1'b1;
          nxt_dms_n = 1'b1;
          nxt_as_n  = 1'b1;
          nxt_state = adc_port_pkg::H_RECOVER;
        end
      end
      adc_port_pkg::H_RECOVER:
      begin
        nxt_left = left_ff - 1'b1;
        if (left_ff == `CNT_W'(1))
          nxt_state = adc_port_pkg::H_IDLE;
        else
        begin
          // Outside end-of-conversion mode the remaining reads follow back to back
          nxt_go    = (wait_mode == adc_port_pkg::WAIT_EOC) ? 1'b0 : go_ff;
          nxt_state = adc_port_pkg::H_WAIT;
        end
      end
      default:
        nxt_state = adc_port_pkg::H_IDLE;
    endcase
    nxt_start_n = use_ext_start ? nxt_ext : (nxt_state != adc_port_pkg::H_START);
    nxt_cs_n    = nxt_dms_n | (nxt_addr != `CONV_ADDR);
    nxt_rd_n    = strobe_bus ? (nxt_as_n | !nxt_rw) : nxt_dms_n;
    nxt_ack_n   = nxt_cs_n;
    nxt_idle    = (nxt_state == adc_port_pkg::H_IDLE);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_ff     <= adc_port_pkg::H_IDLE;
      cnt_ff       <= '0;
      left_ff      <= '0;
      div_ff       <= '0;
      tick_ff      <= 1'b0;
      start_n_ff   <= 1'b1;
      dms_n_ff     <= 1'b1;
      addr_ff      <= '0;
      as_n_ff      <= 1'b1;
      rw_ff        <= 1'b1;
      cs_n_ff      <= 1'b1;
      rd_n_ff      <= 1'b1;
      ack_n_ff     <= 1'b1;
      go_ff        <= 1'b0;
      push_ff      <= 1'b0;
      pdata_ff     <= '0;
      idle_ff      <= 1'b1;
      busy_prev_ff <= 1'b0;
      eoc_prev_ff  <= 1'b1;
      s1_ff        <= 1'b1;
      s2_ff        <= 1'b1;
      s3_ff        <= 1'b1;
      ext_ff       <= 1'b1;
    end
    else
    begin
      state_ff     <= nxt_state;
      cnt_ff       <= nxt_cnt;
      left_ff      <= nxt_left;
      div_ff       <= nxt_div;
      tick_ff      <= nxt_tick;
      start_n_ff   <= nxt_start_n;
      dms_n_ff     <= nxt_dms_n;
      addr_ff      <= nxt_addr;
      as_n_ff      <= nxt_as_n;
      rw_ff        <= nxt_rw;
      cs_n_ff      <= nxt_cs_n;
      rd_n_ff      <= nxt_rd_n;
      ack_n_ff     <= nxt_ack_n;
      go_ff        <= nxt_go;
      push_ff      <= nxt_push;
      pdata_ff     <= nxt_pdata;
      idle_ff      <= nxt_idle;
      busy_prev_ff <= bus.busy;
      eoc_prev_ff  <= bus.eoc_n;
      s1_ff        <= ext_start_n;
      s2_ff        <= s1_ff;
      s3_ff        <= s2_ff;
      ext_ff       <= nxt_ext;
    end
  end
endmodule : host_end

`default_nettype wire

/* tb/adc_port_chk.sv */
// Checker on the wires of the converter read port.
// Assumes one clock for both ends and rst synchronous, active high.
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_consts.svh"

module adc_port_chk (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              conversion_start_n,
  input wire logic              conv_tick,
  input wire logic              chip_select_n,
  input wire logic              read_n,
  input wire logic              write_n,
  input wire logic [`RES_W-1:0] result_bus,
  input wire logic              result_oe_n,
  input wire logic              eoc_n,
  input wire logic              busy,
  input wire logic [`RES_W-1:0] data_seen
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_oe_needs_strobes: assert property (
    !result_oe_n |-> $past(!chip_select_n && !read_n))
    else $error("result driven without chip select and read");
  a_data_no_wait: assert property (
    $fell(read_n) && !chip_select_n |=> !result_oe_n)
    else $error("result not driven one cycle after strobes");
  a_word_held: assert property (
    !result_oe_n && $past(!result_oe_n) |-> $stable(result_bus))
    else $error("result word changed during a read");
  a_read_width: assert property (
    $fell(read_n) |-> !read_n ##1 !read_n ##1 read_n)
    else $error("read strobe not low for two cycles");
  a_read_selected: assert property (
    !read_n |-> !chip_select_n)
    else $error("read strobe without chip select");
  a_eoc_width: assert property (
    $fell(eoc_n) |-> !eoc_n [*8] ##1 eoc_n)
    else $error("end of conversion pulse width wrong");
  a_eoc_in_seq: assert property (
    $fell(eoc_n) |-> $past(busy))
    else $error("end of conversion outside a sequence");
  a_busy_ends_eoc: assert property (
    $fell(busy) |-> $fell(eoc_n))
    else $error("busy fell without the last conversion");
  a_start_taken: assert property (
    $fell(conversion_start_n) && !busy |-> ##[1:3] busy)
    else $error("start not answered by busy");
  a_tick_rate: assert property (
    conv_tick |=> !conv_tick [*7] ##1 conv_tick)
    else $error("conversion clock enable not every eight cycles");
  a_write_idle: assert property (
    write_n)
    else $error("write strobe asserted");

  c_seq_done: cover property ($fell(busy));
  c_eoc: cover property ($fell(eoc_n));
  c_b2b_read: cover property ($rose(read_n) ##[1:3] $fell(read_n));
  c_pull_up: cover property (result_oe_n && data_seen == {`RES_W{1'b1}});
endmodule : adc_port_chk

`default_nettype wire

/* tb/tb.sv */
// Bench joining host end and converter end, with a model of the results.
// Assumes default counts of both ends and a 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_consts.svh"

module tb;
  logic                      clk;
  logic                      rst;
  logic                      start_req;
  logic                      ext_start_n;
  logic                      use_ext_start;
  logic                      strobe_bus;
  logic [1:0]                wait_mode;
  logic [`CNT_W-1:0]         chan_count;
  logic                      result_valid;
  logic                      result_ready;
  logic [`RES_W-1:0]         result_data;
  logic                      host_idle;
  logic [`NUM_CH-1:0]        chan_sel;
  logic [`NUM_CH*`RES_W-1:0] sample_in;
  logic                      stall;
  logic [31:0]               seed;
  logic [31:0]               rseed;
  logic                      eoc_prev;
  logic                      oe_prev;
  int                        bad_count;
  int                        checked;
  int                        eoc_cnt;
  int                        oe_cnt;
  logic [`RES_W-1:0]         exp_q[$];
  logic [`RES_W-1:0]         wire_q[$];

  adc_bus_if bus ();
  host_end host_end_i (.clk(clk), .rst(rst), .bus(bus), .start_req(start_req),
    .ext_start_n(ext_start_n), .use_ext_start(use_ext_start), .strobe_bus(strobe_bus),
    .wait_mode(wait_mode), .chan_count(chan_count), .result_valid(result_valid),
    .result_ready(result_ready), .result_data(result_data), .host_idle(host_idle));
  converter_end converter_end_i (.clk(clk), .rst(rst), .bus(bus), .chan_sel(chan_sel),
    .sample_in(sample_in));
  adc_port_chk adc_port_chk_i (.clk(clk), .rst(rst),
    .conversion_start_n(bus.conversion_start_n), .conv_tick(bus.conv_tick),
    .chip_select_n(bus.chip_select_n), .read_n(bus.read_n), .write_n(bus.write_n),
    .result_bus(bus.result_bus), .result_oe_n(bus.result_oe_n), .eoc_n(bus.eoc_n),
    .busy(bus.busy), .data_seen(bus.data_seen));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %s exp %0h got %0h", name, exp, got);
    end
  endtask : chk

  task automatic end_sim;
    if (bad_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : cyc

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Far side stalls at random so the host end must hold its results
  always @(posedge clk)
  begin
    #2;
    rseed = lfsr(rseed);
    result_ready = !stall && (rseed[0] | rseed[1]);
  end

  // Model queues are popped at the handshake edge, before the design updates
  always @(posedge clk)
  begin
    eoc_prev <= bus.eoc_n;
    oe_prev <= bus.result_oe_n;
    if (!rst && eoc_prev && !bus.eoc_n)
      eoc_cnt++;
    if (!rst && oe_prev && !bus.result_oe_n)
    begin
      if (wait_mode != adc_port_pkg::WAIT_EOC)
        chk("busy at read", 0, bus.busy);
      else
        chk("read after eoc", 1, eoc_cnt > oe_cnt);
      oe_cnt++;
      if (wire_q.size() > 0)
        chk("bus word", wire_q.pop_front(), bus.data_seen);
      else
        chk("extra read", 0, 1);
    end
    if (!rst && result_valid === 1'b1 && result_ready === 1'b1)
    begin
      if (exp_q.size() > 0)
        chk("result word", exp_q.pop_front(), result_data);
      else
        chk("extra result", 0, 1);
    end
  end

  task automatic run_seq(input logic [3:0] sel, input logic [1:0] mode, input logic ext,
                         input logic sb);
    int n;
    logic [`RES_W-1:0] w;
    chan_sel = sel;
    wait_mode = mode;
    use_ext_start = ext;
    strobe_bus = sb;
    chan_count = `CNT_W'($countones(sel));
    for (int i = 0; i < `NUM_CH; i++)
    begin
      seed = lfsr(seed);
      w = seed[`RES_W-1:0];
      sample_in[i*`RES_W +: `RES_W] = w;
      if (sel[i])
      begin
        exp_q.push_back(w);
        wire_q.push_back(w);
      end
    end
    eoc_cnt = 0;
    oe_cnt = 0;
    cyc(1);
    if (ext)
      ext_start_n = 1'b0;
    else
      start_req = 1'b1;
    cyc(4);
    ext_start_n = 1'b1;
    start_req = 1'b0;
    n = 0;
    while (!(host_idle === 1'b1 && (stall || exp_q.size() == 0) && n > 40) && n < 3000)
    begin
      cyc(1);
      n++;
    end
    chk("sequence done", 1, n < 3000);
    chk("eoc pulses", $countones(sel), eoc_cnt);
    chk("bus reads", $countones(sel), oe_cnt);
    chk("busy after", 0, bus.busy);
  endtask : run_seq

  initial
  begin
    #(`CLK_PERIOD_NS * 60000);
    bad_count++;
    end_sim();
  end

  initial
  begin
    int n;
    logic [3:0] sel;
    rst = 1'b1;
    start_req = 1'b0;
    ext_start_n = 1'b1;
    use_ext_start = 1'b0;
    strobe_bus = 1'b0;
    wait_mode = 2'h0;
    chan_count = `CNT_W'(4);
    chan_sel = 4'hf;
    sample_in = '0;
    result_ready = 1'b0;
    stall = 1'b0;
    eoc_prev = 1'b1;
    oe_prev = 1'b1;
    seed = 32'd81551;
    rseed = 32'd81551;
    bad_count = 0;
    checked = 0;
    cyc(12);
    rst = 1'b0;
    run_seq(4'hf, adc_port_pkg::WAIT_BUSY, 1'b0, 1'b0);
    run_seq(4'h5, adc_port_pkg::WAIT_DELAY, 1'b0, 1'b0);
    run_seq(4'hb, adc_port_pkg::WAIT_EOC, 1'b0, 1'b0);
    run_seq(4'h2, adc_port_pkg::WAIT_BUSY, 1'b1, 1'b0);
    run_seq(4'hf, adc_port_pkg::WAIT_EOC, 1'b0, 1'b1);
    for (int k = 0; k < 6; k++)
    begin
      seed = lfsr(seed);
      sel = (seed[3:0] == 4'h0) ? 4'h8 : seed[3:0];
      run_seq(sel, 2'(seed[5:4] % 3), seed[6], seed[7]);
    end
    // Reset in mid-sequence must drop busy, end of conversion, data drive and result valid
    chan_sel = 4'hf;
    wait_mode = 2'h0;
    use_ext_start = 1'b0;
    start_req = 1'b1;
    cyc(1);
    start_req = 1'b0;
    cyc(200);
    rst = 1'b1;
    cyc(2);
    chk("reset busy", 0, bus.busy);
    chk("reset eoc", 1, bus.eoc_n);
    chk("reset oe", 1, bus.result_oe_n);
    chk("reset idle", 1, host_idle);
    chk("reset valid", 0, result_valid);
    rst = 1'b0;
    run_seq(4'h1, adc_port_pkg::WAIT_EOC, 1'b0, 1'b1);
    // Reader stalled over whole sequences: the buffer must keep every word in order
    stall = 1'b1;
    repeat (`FIFO_DEPTH / `NUM_CH)
      run_seq(4'hf, adc_port_pkg::WAIT_BUSY, 1'b0, 1'b0);
    chk("fifo held", `FIFO_DEPTH, exp_q.size());
    chk("fifo valid", 1, result_valid);
    stall = 1'b0;
    n = 0;
    while (exp_q.size() > 0 && n < 200)
    begin
      cyc(1);
      n++;
    end
    chk("fifo drained", 0, exp_q.size());
    chk("fifo empty", 0, result_valid);
    end_sim();
  end
endmodule : tb

`default_nettype wire
